// File: ssr_pkg.sv
// Purpose: Constants for the sectioned static shift register
// Assumes: One system clock at 200 MHz, shift clock sampled as a plain input
// Notes: Section lengths and tap position live here
package ssr_pkg;
  localparam int SSR_NUM_SECT = 4; // Independent sections
  localparam int SSR_SHORT_LEN = 4; // Stages in a short section
  localparam int SSR_LONG_LEN = 5; // Stages in a long section
  localparam int SSR_TAP_POS = 4; // Long-section tap after this stage
  localparam int SSR_CLK_PERIOD_PS = 5000; // System clock period in ps
  localparam int SSR_MAX_SHIFT_KHZ = 5000; // Top shifting rate, 5 MHz
  localparam int SSR_MIN_SHIFT_PERIOD_PS = 1000000000 / SSR_MAX_SHIFT_KHZ;
  // Least spacing of falling edges in system cycles, rounded up
  localparam int SSR_MIN_SHIFT_CYC =
    (SSR_MIN_SHIFT_PERIOD_PS + SSR_CLK_PERIOD_PS - 1) / SSR_CLK_PERIOD_PS;
endpackage : ssr_pkg

// File: ssr_shift_register.sv
// Purpose: Four-section static serial shift register, 18 stages in total
// Assumes: shift_clock and data inputs are synchronous to clk_sys
// Notes: Stages move on a falling shift_clock, seen as a one-cycle enable
`timescale 1ns/1ps
module ssr_shift_register
  import ssr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic shift_clock,
  input wire logic [ssr_pkg::SSR_NUM_SECT-1:0] ser_in,
  output logic [ssr_pkg::SSR_NUM_SECT-1:0] ser_out,
  output logic [1:0] tap_out,
  output logic rate_err
);
  import ssr_pkg::*;

  logic clk_q;
  logic shift_en;
  wire [SSR_NUM_SECT-1:0][SSR_LONG_LEN-1:0] stage_q;
  wire [SSR_NUM_SECT-1:0] last_w;
  logic [7:0] gap_q;
  logic [2:0] fill_q;
  logic full_w;

  // Edge detector; only the clock history is reset, data is not
  // Cleared low so a clock already low at release cannot look like a fall
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= shift_clock;
    end
  end

  // One shared enable for every stage, high-to-low only
  assign shift_en = clk_q & ~shift_clock;

  // Falls seen since reset, saturating; data checks wait until all stages are known
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fill_q <= 3'h0;
    end else if (shift_en && !full_w) begin
      fill_q <= fill_q + 3'h1;
    end
  end

  assign full_w = (fill_q == 3'(SSR_LONG_LEN));

  // Per-section stages; no cross-section path
  generate
    for (genvar s = 0; s < SSR_NUM_SECT; s++) begin : g_sect
      localparam int LEN = (s < 2) ? SSR_SHORT_LEN : SSR_LONG_LEN;
      logic [LEN-1:0] sect_q;
      // Static hold when no edge; stages never reset
      always_ff @(posedge clk_sys) begin
        if (shift_en) begin
          sect_q <= {sect_q[LEN-2:0], ser_in[s]};
        end
      end
      if (LEN < SSR_LONG_LEN) begin : g_pad
        // Unused upper stages of short sections read as zero
        assign stage_q[s] = {{(SSR_LONG_LEN-LEN){1'b0}}, sect_q};
      end else begin : g_full
        assign stage_q[s] = sect_q;
      end
      assign last_w[s] = sect_q[LEN-1];
    end
  endgenerate

  // Last-stage outputs, one per section
  assign ser_out = last_w;

  // Fourth-stage taps of the long sections
  assign tap_out = {stage_q[3][SSR_TAP_POS-1], stage_q[2][SSR_TAP_POS-1]};

  // Edge spacing watch; flags edges closer than the top rate allows
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gap_q <= 8'hff;
      rate_err <= 1'b0;
    end else if (shift_en) begin
      gap_q <= 8'h01;
      rate_err <= rate_err | (gap_q < 8'(SSR_MIN_SHIFT_CYC));
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // Assertions; data checks other than a_indep wait for full_w since stages power up unknown
  property p_shift_short;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en && full_w |=> stage_q[0][0] == $past(ser_in[0]) &&
        ser_out[0] == $past(stage_q[0][2]);
  endproperty
  a_shift_short: assert property (p_shift_short) else $error("short section shift wrong");

  property p_shift_long;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en && full_w |=> stage_q[2][0] == $past(ser_in[2]) &&
        stage_q[3][4] == $past(stage_q[3][3]);
  endproperty
  a_shift_long: assert property (p_shift_long) else $error("long section shift wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (!rstn)
      !shift_en && full_w |=> $stable(stage_q[2]) && $stable(stage_q[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("stage changed without falling edge");

  property p_static;
    @(posedge clk_sys) disable iff (!rstn)
      full_w && (shift_clock && clk_q)[*8] |-> $stable(ser_out);
  endproperty
  a_static: assert property (p_static) else $error("contents lost at rest");

  // Clock resting low must not move data either
  property p_rest_low;
    @(posedge clk_sys) disable iff (!rstn)
      full_w && !clk_q && !shift_clock |=> $stable(stage_q);
  endproperty
  a_rest_low: assert property (p_rest_low) else $error("contents moved at low rest");

  property p_tap;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en && full_w |=> tap_out[1] == $past(stage_q[3][2]);
  endproperty
  a_tap: assert property (p_tap) else $error("tap not fourth stage");

  property p_tap_low;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en && full_w |=> tap_out[0] == $past(stage_q[2][2]);
  endproperty
  a_tap_low: assert property (p_tap_low) else $error("low tap not fourth stage");

  property p_long_len;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en && full_w |=> ser_out[2] == $past(stage_q[2][3]);
  endproperty
  a_long_len: assert property (p_long_len) else $error("long section length wrong");

  property p_short_len;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en && full_w |=> ser_out[1] == $past(stage_q[1][2]);
  endproperty
  a_short_len: assert property (p_short_len) else $error("short section length wrong");

  property p_edge_only;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en |-> $past(shift_clock) && !shift_clock;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("shift not on falling edge");

  property p_indep;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en |=> stage_q[1][0] == $past(ser_in[1]) && stage_q[3][0] == $past(ser_in[3]);
  endproperty
  a_indep: assert property (p_indep) else $error("section input coupled");

  // Rate watch: a close fall sets the flag one cycle later
  property p_rate;
    @(posedge clk_sys) disable iff (!rstn)
      shift_en && (gap_q < 8'(SSR_MIN_SHIFT_CYC)) |=> rate_err;
  endproperty
  a_rate: assert property (p_rate) else $error("fast edge not flagged");

  property p_rate_quiet;
    @(posedge clk_sys) disable iff (!rstn)
      !rate_err && !(shift_en && (gap_q < 8'(SSR_MIN_SHIFT_CYC))) |=> !rate_err;
  endproperty
  a_rate_quiet: assert property (p_rate_quiet) else $error("flag set without fast edge");

  property p_sticky;
    @(posedge clk_sys) disable iff (!rstn)
      rate_err |=> rate_err;
  endproperty
  a_sticky: assert property (p_sticky) else $error("rate flag dropped");

  // Reset clears the flag, clk_q and fill_q and sets gap_q to all ones; stored data survives it
  property p_reset_flag;
    @(posedge clk_sys)
      !rstn |=> !rate_err;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset left rate flag");

  property p_keep_on_reset;
    @(posedge clk_sys)
      !rstn && full_w && !shift_en |=> $stable(stage_q);
  endproperty
  a_keep_on_reset: assert property (p_keep_on_reset) else $error("reset touched data");

  // Main scenarios
  c_shift: cover property (@(posedge clk_sys) disable iff (!rstn) shift_en);
  c_two: cover property (@(posedge clk_sys) disable iff (!rstn) shift_en ##[1:60] shift_en);
  c_err: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(rate_err));
  c_full: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(full_w));
  c_rest: cover property (@(posedge clk_sys) disable iff (!rstn) (!shift_en)[*8]);
endmodule : ssr_shift_register

// File: ssr_drv.sv
// Purpose: Far-side logic driving shift clock and data
// Assumes: Driven on rising clk_sys, non-blocking
// Notes: Clock rests high; data inverted once taken
`timescale 1ns/1ps
module ssr_drv (
  input wire logic clk_sys,
  output logic shift_clock,
  output logic [3:0] ser_in
);
  initial begin
    shift_clock = 1'b1;
    ser_in = 4'h0;
  end
  // One fall, then rest; gap sets spacing
  // One shift clock for every section, as for chained devices
  task automatic shift(input logic [3:0] d, input int gap);
    @(posedge clk_sys);
    shift_clock <= 1'b0;
    ser_in <= d;
    @(posedge clk_sys);
    shift_clock <= 1'b1;
    ser_in <= ~d; // Stale data must not look held
    repeat (gap) @(posedge clk_sys);
  endtask : shift
endmodule : ssr_drv

// File: testbench.sv
// Purpose: Self-checking bench for the shift register
// Assumes: ssr_drv supplies shift clock and data
// Notes: Falls 40 cycles apart except in the rate test
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import ssr_pkg::*;
  logic clk_sys, rstn, shift_clock, rate_err;
  logic [SSR_NUM_SECT-1:0] ser_in, ser_out;
  logic [1:0] tap_out;
  logic [3:0] p [0:7] = '{4'h5, 4'ha, 4'h3, 4'hc, 4'h9, 4'h6, 4'hf, 4'h0};
  int n_fail = 0, checks_done = 0, cyc = 0;
  ssr_shift_register dut (.clk_sys(clk_sys), .rstn(rstn), .shift_clock(shift_clock),
    .ser_in(ser_in), .ser_out(ser_out), .tap_out(tap_out), .rate_err(rate_err));
  ssr_drv drv (.clk_sys(clk_sys), .shift_clock(shift_clock), .ser_in(ser_in));
  // Clock; hang guard well past the ~1270 cycles needed
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  // Distinct data per section exposes crossed paths
  task automatic t_fill();
    for (int k = 0; k < 8; k++) begin
      drv.shift(p[k], 38);
      if (k >= 4) `CHK({tap_out, ser_out}, {p[k-3][3:2], p[k-4][3:2], p[k-3][1:0]})
    end
    `CHK(rate_err, 1'b0)
    $display("t_fill done");
  endtask : t_fill
  // Long rest with clock high
  task automatic t_hold();
    logic [5:0] s;
    s = {tap_out, ser_out};
    repeat (300) @(posedge clk_sys);
    `CHK({tap_out, ser_out}, s)
    $display("t_hold done");
  endtask : t_hold
  // Fast falls still shift and flag; reset clears flag, not data
  task automatic t_rate();
    drv.shift(4'hf, 0);
    drv.shift(4'h0, 2);
    `CHK({rate_err, tap_out, ser_out}, {1'b1, p[6][3:2], p[5][3:2], p[6][1:0]})
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK({rate_err, tap_out, ser_out}, {1'b0, p[6][3:2], p[5][3:2], p[6][1:0]})
    $display("t_rate done");
  endtask : t_rate
  // Outside wiring: section 0 output feeds section 1 as one 8-stage line
  task automatic t_chain();
    logic [7:0] hist;
    hist = 8'h00;
    for (int k = 0; k < 16; k++) begin
      drv.shift({2'b00, ser_out[0], p[k % 8][k % 4]}, 38);
      hist = {hist[6:0], p[k % 8][k % 4]};
      if (k >= 8) `CHK(ser_out[1], hist[7])
    end
    `CHK(rate_err, 1'b0)
    $display("t_chain done");
  endtask : t_chain
  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    rstn = 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_fill();
    t_hold();
    t_rate();
    t_chain();
    finish_test();
  end
endmodule : testbench
